// >>> inc/lcdc_pkg.sv
// How it works
// RL1 - rate is 2*clk/(64*divider), divider 6..127
// RL2 - timing only from link clock, divider input
// RL3 - odd divider uses half-clock steps
// RL4 - 64x oversampled input decimated to one word
// RL5 - output interpolated into 4-bit 64x converter
// RL6 - voice low-pass sits inside decimator; code runs it after the decimator, sidetone and gain
// RL7 - voice filter only while enable set
// RL8 - mute feeds zero samples, converter keeps running
// RL9 - loopback routes output path into input path
// RL10 - sidetone subtracts fixed output fraction when enabled
// RL11 - programmable input attenuation from control field
// RL12 - output words read as two's complement
// RL13 - input words delivered as two's complement
// RL14 - one strobe per sample, one word each way
package lcdc_pkg;
   localparam int OS_RATIO = 64;
   localparam int OS_CNT_W = 6;
   localparam int DIV_W = 8;
   localparam logic [7:0] DIV_MIN = 8'h05;
   localparam logic [7:0] DIV_MAX = 8'h80;
   localparam logic [7:0] HALF_STEP = 8'h02;
   localparam int WORD_W = 14;
   localparam int DAC_W = 4;
   localparam int DEC_W = 11;
   localparam int DEC_SHIFT = 3;
   localparam int VOICE_SHIFT = 2;
   localparam logic [3:0] MOD_POS = 4'h7;
   localparam logic [3:0] MOD_NEG = 4'h9;
   localparam logic [13:0] WORD_RST = 14'h0000;
   localparam int FIFO_DEPTH = 4;
endpackage

// >>> core/lcdc_fifo.sv
`timescale 1ns/1ps
module lcdc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 4
) (
   input wire logic clk, // link clock
   input wire logic sys_rst, // sync reset
   input wire logic [WIDTH-1:0] in_data, // write word
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   output logic [WIDTH-1:0] out_data, // head word
   output logic out_valid, // not empty
   input wire logic out_ready // pop
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("lcdc_fifo depth must be a power of two, at least 2");
      end
   endgenerate
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;
   always_comb begin
      in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid = wr_ptr != rd_ptr;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

// >>> core/lcdc_top.sv
`timescale 1ns/1ps
module lcdc_top
   import lcdc_pkg::*;
#(
   parameter int ATT_W = 1,
   parameter int BUF_DEPTH = lcdc_pkg::FIFO_DEPTH
) (
   input wire logic clk, // link clock, 250 MHz
   input wire logic sys_rst, // sync reset, active high
   input wire logic [lcdc_pkg::DIV_W-1:0] rate_div, // sample rate divider
   input wire logic voice_filt_en, // voice low-pass enable
   input wire logic mute, // output mute
   input wire logic loopback, // output path into input path
   input wire logic sidetone_en, // sidetone suppression enable
   input wire logic [ATT_W-1:0] atten_sel, // input attenuation, 6 dB steps
   input wire logic adc_bit, // input modulator bit stream
   input wire logic [lcdc_pkg::WORD_W-1:0] tx_data, // output sample word
   input wire logic tx_valid, // output word offered
   output logic tx_ready, // buffer can take a word
   output logic [lcdc_pkg::WORD_W-1:0] rx_data, // input sample word
   output logic rx_valid, // input word pulse
   output logic [lcdc_pkg::DAC_W-1:0] dac_code, // 4-bit converter code
   output logic sample_strobe, // one pulse per sample
   output logic div_err // divider out of range
);
   generate
      if (ATT_W < 1 || ATT_W > 3) begin : g_chk
         $error("lcdc_top atten width must be 1..3");
      end
      // the buffer needs room for at least one word in flight
      if (BUF_DEPTH < 2) begin : g_chk_buf
         $error("lcdc_top buffer depth must be at least 2");
      end
      // the tick counter must wrap exactly once per sample
      if ((1 << OS_CNT_W) != OS_RATIO) begin : g_chk_os
         $error("lcdc_top oversample counter width does not match the ratio");
      end
   endgenerate

   // clamp a widened result back into one sample word
   function automatic logic signed [WORD_W-1:0] sat_word(input logic signed [WORD_W+1:0] v);
      logic signed [WORD_W+1:0] hi;
      logic signed [WORD_W+1:0] lo;
      hi = (WORD_W+2)'(2 ** (WORD_W-1) - 1);
      lo = -hi - (WORD_W+2)'(1);
      if (v > hi) begin
         sat_word = WORD_W'(hi);
      end else if (v < lo) begin
         sat_word = WORD_W'(lo);
      end else begin
         sat_word = WORD_W'(v);
      end
   endfunction

   // fifo between host words and the sample clock
   // tx_ready comes straight from the buffer, so a pop frees room on the next clock
   logic [WORD_W-1:0] buf_data;
   logic buf_valid, buf_pop;
   lcdc_fifo #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop)
   );

   // rate generator: counts half periods, so odd dividers alternate between two tick gaps one clock apart
   logic [DIV_W-1:0] half_acc, next_half_acc;
   logic [OS_CNT_W-1:0] os_cnt, next_os_cnt;
   logic os_tick, next_os_tick, strobe, next_strobe, next_div_err;
   logic [DIV_W:0] acc_sum;
   logic [DIV_W-1:0] last_div, next_last_div;
   always_comb begin
      acc_sum = {1'b0, half_acc} + {1'b0, HALF_STEP};
      // out-of-range divider freezes the phase and all ticks
      next_div_err = !(rate_div > DIV_MIN && rate_div < DIV_MAX); // RL1
      next_half_acc = half_acc;
      next_last_div = rate_div;
      next_os_tick = 1'b0;
      next_os_cnt = os_cnt;
      next_strobe = 1'b0;
      if (!next_div_err) begin
         if (rate_div != last_div) begin
            // new divider restarts the phase instead of a burst of catch-up ticks
            next_half_acc = '0;
         end else if (acc_sum >= {1'b0, rate_div}) begin // RL3
            next_half_acc = DIV_W'(acc_sum - {1'b0, rate_div});
            next_os_tick = 1'b1; // RL1
         end else begin
            next_half_acc = DIV_W'(acc_sum);
         end
      end
      if (os_tick) begin
         next_os_cnt = os_cnt + OS_CNT_W'(1);
         next_strobe = os_cnt == OS_CNT_W'(OS_RATIO - 1); // RL14
      end
   end
   always_ff @(posedge clk) begin // RL2
      if (sys_rst) begin
         half_acc <= '0;
         last_div <= '0;
         os_tick <= 1'b0;
         os_cnt <= '0;
         strobe <= 1'b0;
         div_err <= 1'b1;
      end else begin
         half_acc <= next_half_acc;
         last_div <= next_last_div;
         os_tick <= next_os_tick;
         os_cnt <= next_os_cnt;
         strobe <= next_strobe;
         div_err <= next_div_err;
      end
   end
   assign sample_strobe = strobe;

   // output path: word per strobe, linear ramp, first-order noise shaping
   logic signed [WORD_W-1:0] out_cur, out_prev, next_out_cur, next_out_prev;
   logic signed [WORD_W+OS_CNT_W:0] ramp, next_ramp;
   logic signed [WORD_W:0] shaped;
   // step taken one bit wider so full-scale swings cannot wrap
   logic signed [WORD_W:0] ramp_step;
   logic [WORD_W-DAC_W-1:0] q_err, next_q_err;
   logic [DAC_W-1:0] next_dac;
   always_comb begin
      buf_pop = strobe; // RL14
      next_out_cur = out_cur;
      next_out_prev = out_prev;
      next_ramp = ramp;
      next_q_err = q_err;
      next_dac = dac_code;
      shaped = '0;
      ramp_step = (WORD_W+1)'(out_cur) - (WORD_W+1)'(out_prev);
      if (strobe) begin
         next_out_prev = out_cur;
         // underrun plays silence rather than repeating a stale word
         next_out_cur = (mute || !buf_valid) ? WORD_RST : $signed(buf_data); // RL8 RL12
         next_ramp = (WORD_W+OS_CNT_W+1)'(out_cur) <<< OS_CNT_W;
      end else if (os_tick) begin
         next_ramp = ramp + (WORD_W+OS_CNT_W+1)'(ramp_step); // RL5
      end
      if (os_tick) begin
         shaped = (WORD_W+1)'(ramp >>> OS_CNT_W) + $signed({1'b0, q_err});
         // clamp keeps the shaper from wrapping at full scale
         if (shaped > (WORD_W+1)'(2 ** (WORD_W-1) - 1)) begin
            shaped = (WORD_W+1)'(2 ** (WORD_W-1) - 1);
         end
         next_dac = shaped[WORD_W-1 -: DAC_W]; // RL5
         next_q_err = shaped[WORD_W-DAC_W-1:0];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_cur <= '0;
         out_prev <= '0;
         ramp <= '0;
         q_err <= '0;
         dac_code <= '0;
      end else begin
         out_cur <= next_out_cur;
         out_prev <= next_out_prev;
         ramp <= next_ramp;
         q_err <= next_q_err;
         dac_code <= next_dac;
      end
   end

   // input path: integrate-and-dump decimator, then sidetone, gain, voice filter
   logic signed [DEC_W-1:0] dec_sum, next_dec_sum, dec_total;
   logic signed [DAC_W-1:0] in_val;
   logic signed [WORD_W-1:0] dec_word, st_word, att_word, voice, next_voice;
   logic [WORD_W-1:0] next_rx_data;
   logic next_rx_valid;
   // widened so sidetone and the voice filter saturate instead of wrapping
   logic signed [WORD_W+1:0] st_cut, voice_step;
   always_comb begin
      if (loopback) begin
         in_val = $signed(dac_code); // RL9
      end else begin
         in_val = adc_bit ? $signed(MOD_POS) : $signed(MOD_NEG);
      end
      dec_total = dec_sum + DEC_W'(in_val);
      next_dec_sum = dec_sum;
      if (strobe) begin
         next_dec_sum = '0;
      end else if (os_tick) begin
         next_dec_sum = dec_total; // RL4
      end
      dec_word = WORD_W'(dec_sum) <<< DEC_SHIFT;
      // fixed 3/4 of the line output, close to the resistor ratio
      st_cut = (WORD_W+2)'(out_cur >>> 1) + (WORD_W+2)'(out_cur >>> 2);
      st_word = sidetone_en ? sat_word((WORD_W+2)'(dec_word) - st_cut) : dec_word; // RL10
      att_word = st_word >>> atten_sel; // RL11
      voice_step = ((WORD_W+2)'(att_word) - (WORD_W+2)'(voice)) >>> VOICE_SHIFT;
      next_voice = voice;
      if (strobe) begin
         next_voice = sat_word((WORD_W+2)'(voice) + voice_step); // RL6
      end
      next_rx_valid = strobe; // RL14
      next_rx_data = rx_data;
      if (strobe) begin
         next_rx_data = voice_filt_en ? next_voice : att_word; // RL7 RL13
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dec_sum <= '0;
         voice <= '0;
         rx_data <= '0;
         rx_valid <= 1'b0;
      end else begin
         dec_sum <= next_dec_sum;
         voice <= next_voice;
         rx_data <= next_rx_data;
         rx_valid <= next_rx_valid;
      end
   end
endmodule

// >>> verif/lcdc_checker.sv
`timescale 1ns/1ps
module lcdc_checker
   import lcdc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic sys_rst, // reset
   input wire logic [lcdc_pkg::DIV_W-1:0] rate_div, // divider
   input wire logic tx_valid, // offer
   input wire logic tx_ready, // room
   input wire logic [lcdc_pkg::WORD_W-1:0] rx_data, // word
   input wire logic rx_valid, // pulse
   input wire logic sample_strobe, // strobe
   input wire logic div_err // flag
);
   logic [15:0] gap;
   logic [1:0] seen;
   logic [7:0] pdiv;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // two strobes after a change, so the residue has settled
   always_ff @(posedge clk) begin
      pdiv <= rate_div;
      gap <= sample_strobe ? 16'h0001 : gap + 16'h0001;
      if (sys_rst || pdiv != rate_div) seen <= 2'h0;
      else if (sample_strobe && seen != 2'h2) seen <= seen + 2'h1;
   end
   chk_period_exact: assert property (sample_strobe && seen == 2'h2 |->
      gap == {3'h0, rate_div, 5'h00}) else $error("bad period");
   chk_rx_follows: assert property (sample_strobe |=> rx_valid)
      else $error("no word");
   chk_rx_cause: assert property (rx_valid |-> $past(sample_strobe))
      else $error("stray word");
   chk_rx_holds: assert property (!rx_valid |-> $stable(rx_data))
      else $error("word moved");
   chk_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
      else $error("strobes close");
   chk_div_range: assert property (1'b1 |=>
      div_err == ($past(rate_div) < 8'h06 || $past(rate_div) > 8'h7F)) else $error("bad flag");
   chk_bad_idle: assert property (div_err [*3] |-> !sample_strobe)
      else $error("strobe on bad divider");
   chk_full_cause: assert property ($fell(tx_ready) |-> $past(tx_valid))
      else $error("full without take");
   chk_pop_cause: assert property ($rose(tx_ready) |->
      $past(sample_strobe) || $past(sample_strobe, 2)) else $error("pop without strobe");
   cover property (sample_strobe && seen == 2'h2);
   cover property ($fell(tx_ready));
   cover property ($rose(div_err));
endmodule

bind lcdc_top lcdc_checker u_chk (.clk(clk), .sys_rst(sys_rst), .rate_div(rate_div),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
   .sample_strobe(sample_strobe), .div_err(div_err));

// >>> verif/lcdc_host_model.sv
`timescale 1ns/1ps
module lcdc_host_model
   import lcdc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic go, // keep sending
   input wire logic [lcdc_pkg::WORD_W-1:0] word, // signed word
   input wire logic tx_ready, // room
   output logic [lcdc_pkg::WORD_W-1:0] tx_data, // offer
   output logic tx_valid, // valid
   output int taken // accepted
);
   logic took = 1'b0;
   logic go_q = 1'b0;
   logic [lcdc_pkg::WORD_W-1:0] word_q = 14'h0000;
   initial begin
      tx_valid = 1'b0;
      tx_data = 14'h0000;
      taken = 0;
   end
   always @(posedge clk) begin
      took <= tx_valid && tx_ready;
      // bench controls taken on the rising edge, away from the offer edge
      go_q <= go;
      word_q <= word;
      taken <= taken + int'(tx_valid && tx_ready);
   end
   // offer held until taken; idle data toggles, never stale
   always @(negedge clk) begin
      if (!tx_valid || took) begin
         tx_valid <= go_q;
         tx_data <= go_q ? word_q : ~tx_data;
      end
   end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   import lcdc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] rate_div = 8'h06;
   logic vf = 1'b0, mu = 1'b0, lb = 1'b0, st = 1'b0, att = 1'b0, adc = 1'b0, go = 1'b0;
   logic [13:0] word = 14'h1000, txd, rxd, rp, r;
   logic txv, txr, rxv, stb, derr;
   logic [3:0] dac;
   logic [7:0] dv[4] = '{8'h05, 8'h06, 8'h7F, 8'h80};
   int taken, n, errors = 0, checks_done = 0;
   always #2 clk = ~clk;
   lcdc_top dut (.clk(clk), .sys_rst(sys_rst), .rate_div(rate_div), .voice_filt_en(vf),
      .mute(mu), .loopback(lb), .sidetone_en(st), .atten_sel(att), .adc_bit(adc),
      .tx_data(txd), .tx_valid(txv), .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv),
      .dac_code(dac), .sample_strobe(stb), .div_err(derr));
   lcdc_host_model host (.clk(clk), .go(go), .word(word), .tx_ready(txr), .tx_data(txd),
      .tx_valid(txv), .taken(taken));
   task automatic check(input string what, input logic [13:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // n ends as the clock count of the last strobe gap
   task automatic strobe(input int k);
      repeat (k) begin
         n = 1;
         @(negedge clk);
         while (stb !== 1'b1 && n < 9999) begin
            @(negedge clk);
            n++;
         end
         if (stb !== 1'b1) begin
            errors++;
         end
      end
   endtask
   task automatic settle(output logic [13:0] v);
      strobe(8);
      @(negedge clk);
      v = rxd;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      check("ready", 14'(txr), 14'h1);
      for (int d = 6; d < 8; d++) begin
         rate_div = 8'(d);
         strobe(3);
         check("period", 14'(n), 14'(32 * d));
         @(negedge clk);
         check("rx_valid", 14'(rxv), 14'h1);
      end
      go = 1'b1;
      repeat (12) @(negedge clk);
      check("full", 14'(txr), 14'h0);
      check("taken", 14'(taken), 14'h4);
      strobe(1);
      repeat (3) @(negedge clk);
      check("one_pop", 14'(taken), 14'h5);
      lb = 1'b1;
      settle(rp);
      check("lb_pos", 14'(rp[13] == 1'b0 && rp != 14'h0), 14'h1);
      check("dac_lb", 14'(dac), 14'h4);
      att = 1'b1;
      settle(r);
      check("atten", 14'($signed(r) < $signed(rp)), 14'h1);
      att = 1'b0;
      st = 1'b1;
      settle(r);
      check("sidetone", 14'($signed(r) < $signed(rp)), 14'h1);
      st = 1'b0;
      mu = 1'b1;
      word = 14'h3000;
      settle(r);
      check("mute", r, 14'h0);
      check("mute_dac", 14'(dac), 14'h0);
      mu = 1'b0;
      vf = 1'b1;
      settle(r);
      check("lb_neg", 14'(r[13]), 14'h1);
      lb = 1'b0;
      adc = 1'b1;
      settle(r);
      check("adc_pos", 14'(r[13]), 14'h0);
      check("voice_lag", 14'(r != 14'h0E00), 14'h1);
      foreach (dv[i]) begin
         rate_div = dv[i];
         repeat (4) @(negedge clk);
         check("div_err", 14'(derr), 14'(dv[i] < 8'h06 || dv[i] > 8'h7F));
      end
      report_and_stop();
   end
   initial begin
      #120000;
      errors++;
      report_and_stop();
   end
endmodule
